/* include/usas_pkg.sv */
// shared constants and types for the serial engine address, stall and status logic
package usas_pkg;
   // register selects
   localparam logic [1:0] REG_ADDR = 2'h0;
   localparam logic [1:0] REG_OUT_STALL = 2'h1;
   localparam logic [1:0] REG_IN_STALL = 2'h2;
   localparam logic [1:0] REG_STATUS = 2'h3;

   localparam int NUM_EP = 8;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [6:0] ADDR_RESET = 7'h00;
   localparam logic [NUM_EP-1:0] STALL_CLEAR = 8'h00;

   // address and wake-up register fields
   localparam int ADDR_MSB = 7;
   localparam int ADDR_LSB = 1;
   localparam int WAKE_BIT = 0;

   // status register fields
   localparam int NAK_MASK_BIT = 7;
   localparam int CRC_BIT = 6;
   localparam int NORESP_BIT = 4;
   localparam int IN_BIT = 3;
   localparam int OUT_BIT = 2;
   localparam int FIFO_ERR_BIT = 1;
   localparam int ADDRESS_UPDATE_TIMING_BIT = 0;
   // flags cleared by writing zero; writing one leaves them alone
   localparam logic [7:0] STATUS_FLAG_MASK = 8'h56;
   localparam logic [7:0] ADDRESS_UPDATE_TIMING_MASK = 8'h01;

   localparam int EP_IDX_W = 3;

   typedef enum logic [1:0] {
      TOK_OUT,
      TOK_IN,
      TOK_SETUP
   } usas_token_t;

   typedef enum logic [1:0] {
      CMD_READ,
      CMD_WRITE,
      CMD_STALL,
      CMD_SET_ADDR
   } usas_cmd_t;
endpackage : usas_pkg

/* include/usas_reg_if.sv */
// register access link between the firmware agent and the serial engine
`timescale 1ns/1ps
`default_nettype none
interface usas_reg_if;
   logic [1:0] regSel;
   logic wrEn;
   logic rdEn;
   logic [7:0] wrData;
   logic [7:0] rdData;
   logic rdValid;
   logic setupSeen;

   modport device (
      input regSel,
      input wrEn,
      input rdEn,
      input wrData,
      output rdData,
      output rdValid,
      output setupSeen
   );

   modport host (
      output regSel,
      output wrEn,
      output rdEn,
      output wrData,
      input rdData,
      input rdValid,
      input setupSeen
   );
endinterface : usas_reg_if
`default_nettype wire

/* rtl/usas_sticky.sv */
// sticky flag: hardware set wins over any clear in the same cycle
`timescale 1ns/1ps
`default_nettype none
module usas_sticky (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // control
   input wire logic setPulse,
   input wire logic clrPulse,
   // state
   output logic flag
);
   logic next_flag;

   always_comb begin
      next_flag = flag;
      if (setPulse) begin
         next_flag = 1'b1;
      end else if (clrPulse) begin
         next_flag = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         flag <= 1'b0;
      end else begin
         flag <= next_flag;
      end
   end
endmodule : usas_sticky
`default_nettype wire

/* rtl/usas_device.sv */
// serial engine address, stall and status registers with token address check
// Notes on behaviour
// - seven-bit address in upper register bits
// - address register bit zero enables remote wake-up
// - address register resets to zero
// - firmware loads address after setup stage ends
// - one OUT stall bit per endpoint
// - one IN stall bit per endpoint
// - firmware stalls endpoint on improper operation
// - bus reset or setup clears all stalls
// - NAK interrupt unless mask bit set
// - sticky CRC, PID or stuffing error flag
// - sticky no-response error flag
// - read-only flag for current IN token
// - OUT flag set by data, cleared by setup
// - sticky FIFO access error flag
// - address adopted on write or after IN
// - firmware clears update bit after next setup
// - unimplemented bits read as zero
`timescale 1ns/1ps
`default_nettype none
module usas_device (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // register link
   usas_reg_if.device regPort,
   // token events from the receiver
   input wire logic tokenValid,
   input wire usas_pkg::usas_token_t tokenKind,
   input wire logic [6:0] tokenAddr,
   input wire logic busReset,
   input wire logic outDataRx,
   input wire logic inReadDone,
   // error events
   input wire logic crcErr,
   input wire logic pidErr,
   input wire logic stuffErr,
   input wire logic noResponse,
   input wire logic fifoErr,
   input wire logic nakSent,
   // engine outputs
   output logic tokenAccept,
   output logic [6:0] deviceAddr,
   output logic remoteWakeEn,
   output logic [usas_pkg::NUM_EP-1:0] outStall,
   output logic [usas_pkg::NUM_EP-1:0] inStall,
   output logic nakIrq
);
   logic [7:0] addrReg;
   logic nakMask;
   logic asetBit;
   logic addrPending;
   logic inToken;
   logic [7:0] rdData;
   logic rdValid;
   logic setupSeen;

   logic [7:0] next_addrReg;
   logic [usas_pkg::NUM_EP-1:0] next_outStall;
   logic [usas_pkg::NUM_EP-1:0] next_inStall;
   logic next_nakMask;
   logic next_asetBit;
   logic [6:0] next_deviceAddr;
   logic next_addrPending;
   logic next_inToken;
   logic [7:0] next_rdData;
   logic next_rdValid;
   logic next_setupSeen;
   logic next_nakIrq;

   logic wrAddr;
   logic wrOut;
   logic wrIn;
   logic wrStatus;
   logic setupAcc;
   logic crcFlag;
   logic noRespFlag;
   logic outFlag;
   logic fifoFlag;
   logic [7:0] statusValue;

   assign tokenAccept = tokenValid && (tokenAddr == deviceAddr);
   assign setupAcc = tokenAccept && (tokenKind == usas_pkg::TOK_SETUP);

   assign wrAddr = regPort.wrEn && (regPort.regSel == usas_pkg::REG_ADDR);
   assign wrOut = regPort.wrEn && (regPort.regSel == usas_pkg::REG_OUT_STALL);
   assign wrIn = regPort.wrEn && (regPort.regSel == usas_pkg::REG_IN_STALL);
   assign wrStatus = regPort.wrEn && (regPort.regSel == usas_pkg::REG_STATUS);

   assign remoteWakeEn = addrReg[usas_pkg::WAKE_BIT];

   // error and indicator flags
   usas_sticky crcCell (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .setPulse(crcErr || pidErr || stuffErr),
      .clrPulse(wrStatus && !regPort.wrData[usas_pkg::CRC_BIT]),
      .flag(crcFlag)
   );

   usas_sticky noRespCell (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .setPulse(noResponse),
      .clrPulse(wrStatus && !regPort.wrData[usas_pkg::NORESP_BIT]),
      .flag(noRespFlag)
   );

   usas_sticky outCell (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .setPulse(outDataRx),
      .clrPulse(setupAcc
         || (wrStatus && !regPort.wrData[usas_pkg::OUT_BIT])),
      .flag(outFlag)
   );

   usas_sticky fifoCell (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .setPulse(fifoErr),
      .clrPulse(wrStatus && !regPort.wrData[usas_pkg::FIFO_ERR_BIT]),
      .flag(fifoFlag)
   );

   always_comb begin
      statusValue = usas_pkg::REG_RESET;
      statusValue[usas_pkg::NAK_MASK_BIT] = nakMask;
      statusValue[usas_pkg::CRC_BIT] = crcFlag;
      statusValue[usas_pkg::NORESP_BIT] = noRespFlag;
      statusValue[usas_pkg::IN_BIT] = inToken;
      statusValue[usas_pkg::OUT_BIT] = outFlag;
      statusValue[usas_pkg::FIFO_ERR_BIT] = fifoFlag;
      statusValue[usas_pkg::ADDRESS_UPDATE_TIMING_BIT] = asetBit;
   end

   always_comb begin
      next_addrReg = addrReg;
      next_outStall = outStall;
      next_inStall = inStall;
      next_nakMask = nakMask;
      next_asetBit = asetBit;
      next_deviceAddr = deviceAddr;
      next_addrPending = addrPending;
      next_inToken = inToken;
      next_rdData = rdData;
      next_rdValid = 1'b0;
      next_setupSeen = setupAcc;
      next_nakIrq = nakSent && !nakMask;

      if (wrAddr) begin
         next_addrReg = regPort.wrData;
      end

      // hardware clear beats a firmware write in the same cycle
      if (busReset || setupAcc) begin
         next_outStall = usas_pkg::STALL_CLEAR;
         next_inStall = usas_pkg::STALL_CLEAR;
      end else begin
         if (wrOut) begin
            next_outStall = regPort.wrData[usas_pkg::NUM_EP-1:0];
         end
         if (wrIn) begin
            next_inStall = regPort.wrData[usas_pkg::NUM_EP-1:0];
         end
      end

      if (wrStatus) begin
         next_nakMask = regPort.wrData[usas_pkg::NAK_MASK_BIT];
         next_asetBit = regPort.wrData[usas_pkg::ADDRESS_UPDATE_TIMING_BIT];
      end

      // address adoption
      if (wrAddr && !asetBit) begin
         next_deviceAddr =
            regPort.wrData[usas_pkg::ADDR_MSB:usas_pkg::ADDR_LSB];
         next_addrPending = 1'b0;
      end else if (wrAddr) begin
         next_addrPending = 1'b1;
      end else if (addrPending && inReadDone) begin
         next_deviceAddr =
            addrReg[usas_pkg::ADDR_MSB:usas_pkg::ADDR_LSB];
         next_addrPending = 1'b0;
      end

      if (tokenAccept) begin
         next_inToken = (tokenKind == usas_pkg::TOK_IN);
      end else if (busReset) begin
         next_inToken = 1'b0;
      end

      if (regPort.rdEn) begin
         next_rdValid = 1'b1;
         unique case (regPort.regSel)
            usas_pkg::REG_ADDR: next_rdData = addrReg;
            usas_pkg::REG_OUT_STALL: next_rdData = outStall;
            usas_pkg::REG_IN_STALL: next_rdData = inStall;
            usas_pkg::REG_STATUS: next_rdData = statusValue;
         endcase
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         addrReg <= usas_pkg::REG_RESET;
         outStall <= usas_pkg::STALL_CLEAR;
         inStall <= usas_pkg::STALL_CLEAR;
         nakMask <= 1'b0;
         asetBit <= 1'b0;
         deviceAddr <= usas_pkg::ADDR_RESET;
         addrPending <= 1'b0;
         inToken <= 1'b0;
         rdData <= usas_pkg::REG_RESET;
         rdValid <= 1'b0;
         setupSeen <= 1'b0;
         nakIrq <= 1'b0;
      end else begin
         addrReg <= next_addrReg;
         outStall <= next_outStall;
         inStall <= next_inStall;
         nakMask <= next_nakMask;
         asetBit <= next_asetBit;
         deviceAddr <= next_deviceAddr;
         addrPending <= next_addrPending;
         inToken <= next_inToken;
         rdData <= next_rdData;
         rdValid <= next_rdValid;
         setupSeen <= next_setupSeen;
         nakIrq <= next_nakIrq;
      end
   end

   assign regPort.rdData = rdData;
   assign regPort.rdValid = rdValid;
   assign regPort.setupSeen = setupSeen;
endmodule : usas_device
`default_nettype wire

/* rtl/usas_host.sv */
// firmware-side agent: register commands, stall marking, address hand-off
`timescale 1ns/1ps
`default_nettype none
module usas_host (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // register link
   usas_reg_if.host regPort,
   // command port
   input wire logic cmdValid,
   input wire usas_pkg::usas_cmd_t cmdOp,
   input wire logic [1:0] cmdSel,
   input wire logic [7:0] cmdData,
   output logic cmdReady,
   // control transfer progress
   input wire logic setupStageDone,
   // read answer
   output logic [7:0] readData,
   output logic readValid
);
   typedef enum {ST_IDLE, ST_RDREQ, ST_RDWAIT, ST_WRITE} usas_hstate_t;
   typedef enum {JOB_READ, JOB_STALL, JOB_ADDRESS_UPDATE_TIMING} usas_job_t;

   usas_hstate_t state;
   usas_job_t job;
   logic [1:0] sel;
   logic [7:0] data;
   logic [7:0] addrHold;
   logic addrPending;
   logic stageDone;
   logic deferWatch;
   logic setupLatched;

   usas_hstate_t next_state;
   usas_job_t next_job;
   logic [1:0] next_sel;
   logic [7:0] next_data;
   logic [7:0] next_addrHold;
   logic next_addrPending;
   logic next_stageDone;
   logic next_deferWatch;
   logic next_setupLatched;
   logic [7:0] next_readData;
   logic next_readValid;

   logic addrGo;
   logic asetGo;

   assign addrGo = addrPending && stageDone;
   assign asetGo = deferWatch && setupLatched;
   assign cmdReady = (state == ST_IDLE) && !addrGo && !asetGo;

   always_comb begin
      next_state = state;
      next_job = job;
      next_sel = sel;
      next_data = data;
      next_addrHold = addrHold;
      next_addrPending = addrPending;
      next_stageDone = stageDone || setupStageDone;
      next_deferWatch = deferWatch;
      next_setupLatched = setupLatched || regPort.setupSeen;
      next_readData = readData;
      next_readValid = 1'b0;

      unique case (state)
         ST_IDLE: begin
            if (addrGo) begin
               next_sel = usas_pkg::REG_ADDR;
               next_data = addrHold;
               next_addrPending = 1'b0;
               next_stageDone = setupStageDone;
               next_deferWatch = 1'b1;
               next_setupLatched = regPort.setupSeen;
               next_state = ST_WRITE;
            end else if (asetGo) begin
               next_job = JOB_ADDRESS_UPDATE_TIMING;
               next_sel = usas_pkg::REG_STATUS;
               next_deferWatch = 1'b0;
               next_setupLatched = regPort.setupSeen;
               next_state = ST_RDREQ;
            end else if (cmdValid) begin
               next_sel = cmdSel;
               next_data = cmdData;
               unique case (cmdOp)
                  usas_pkg::CMD_READ: begin
                     next_job = JOB_READ;
                     next_state = ST_RDREQ;
                  end
                  usas_pkg::CMD_WRITE: next_state = ST_WRITE;
                  usas_pkg::CMD_STALL: begin
                     next_job = JOB_STALL;
                     next_state = ST_RDREQ;
                  end
                  usas_pkg::CMD_SET_ADDR: begin
                     next_addrHold = cmdData;
                     next_addrPending = 1'b1;
                     next_stageDone = setupStageDone;
                  end
               endcase
            end
         end
         ST_RDREQ: next_state = ST_RDWAIT;
         ST_RDWAIT: begin
            if (regPort.rdValid) begin
               unique case (job)
                  JOB_READ: begin
                     next_readData = regPort.rdData;
                     next_readValid = 1'b1;
                     next_state = ST_IDLE;
                  end
                  JOB_STALL: begin
                     next_data = regPort.rdData
                        | (8'h01 << data[usas_pkg::EP_IDX_W-1:0]);
                     next_state = ST_WRITE;
                  end
                  JOB_ADDRESS_UPDATE_TIMING: begin
                     next_data = (regPort.rdData
                        | usas_pkg::STATUS_FLAG_MASK)
                        & ~usas_pkg::ADDRESS_UPDATE_TIMING_MASK;
                     next_state = ST_WRITE;
                  end
               endcase
            end
         end
         ST_WRITE: next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         job <= JOB_READ;
         sel <= usas_pkg::REG_ADDR;
         data <= usas_pkg::REG_RESET;
         addrHold <= usas_pkg::REG_RESET;
         addrPending <= 1'b0;
         stageDone <= 1'b0;
         deferWatch <= 1'b0;
         setupLatched <= 1'b0;
         readData <= usas_pkg::REG_RESET;
         readValid <= 1'b0;
      end else begin
         state <= next_state;
         job <= next_job;
         sel <= next_sel;
         data <= next_data;
         addrHold <= next_addrHold;
         addrPending <= next_addrPending;
         stageDone <= next_stageDone;
         deferWatch <= next_deferWatch;
         setupLatched <= next_setupLatched;
         readData <= next_readData;
         readValid <= next_readValid;
      end
   end

   assign regPort.regSel = sel;
   assign regPort.wrData = data;
   assign regPort.wrEn = (state == ST_WRITE);
   assign regPort.rdEn = (state == ST_RDREQ);
endmodule : usas_host
`default_nettype wire

/* test/usas_reg_asserts.sv */
// register link assertions between the host agent and the engine
`timescale 1ns/1ps
`default_nettype none
module usas_reg_asserts (
   // clock and reset
   input wire logic clk_sys,
   input wire logic rstn,
   // register link
   input wire logic [1:0] regSel,
   input wire logic wrEn,
   input wire logic rdEn,
   input wire logic [7:0] wrData,
   input wire logic [7:0] rdData,
   input wire logic rdValid,
   input wire logic setupSeen
);
   logic [7:0] lastAddr;
   logic [1:0] rdSelQ;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   // shadow of the last address byte and of the register being read
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         lastAddr <= usas_pkg::REG_RESET;
         rdSelQ <= usas_pkg::REG_ADDR;
      end else begin
         if (wrEn && regSel == usas_pkg::REG_ADDR) begin
            lastAddr <= wrData;
         end
         if (rdEn) begin
            rdSelQ <= regSel;
         end
      end
   end
   sequence s_stall_read;
      rdValid && (rdSelQ == usas_pkg::REG_OUT_STALL ||
                  rdSelQ == usas_pkg::REG_IN_STALL);
   endsequence
   sequence s_status_read;
      rdValid && rdSelQ == usas_pkg::REG_STATUS;
   endsequence
   a_read_answer: assert property (rdEn |=> rdValid)
      else $error("read request not answered");
   a_read_cause: assert property (rdValid |-> $past(rdEn))
      else $error("read answer without request");
   a_data_hold: assert property (!rdValid |-> $stable(rdData))
      else $error("read data moved without answer");
   a_addr_readback: assert property (
      rdValid && rdSelQ == usas_pkg::REG_ADDR |-> rdData == lastAddr)
      else $error("address register readback wrong");
   a_rsvd_zero: assert property (s_status_read |-> rdData[5] == 1'b0)
      else $error("unused status bit reads one");
   a_setup_pulse: assert property (setupSeen |=> !setupSeen)
      else $error("setup indication longer than one cycle");
   a_wr_pulse: assert property (wrEn |=> !wrEn)
      else $error("write strobe longer than one cycle");
   a_no_overlap: assert property (!(wrEn && rdEn))
      else $error("read and write together");
   a_stall_rmw: assert property (
      s_stall_read ##1 (wrEn && regSel == rdSelQ) |->
      (wrData & rdData) == rdData && $onehot0(wrData ^ rdData))
      else $error("stall update is not one added bit");
   a_address_update_timing_clear: assert property (
      s_status_read ##1 (wrEn && regSel == usas_pkg::REG_STATUS) |->
      wrData[usas_pkg::ADDRESS_UPDATE_TIMING_BIT] == 1'b0 &&
      (wrData & usas_pkg::STATUS_FLAG_MASK) == usas_pkg::STATUS_FLAG_MASK)
      else $error("status write-back wrong");
endmodule : usas_reg_asserts
`default_nettype wire

/* test/usas_sie_address_stall_status_bench.sv */
// self-checking bench: host agent and engine joined over the register link
`timescale 1ns/1ps
`default_nettype none
module usas_sie_address_stall_status_bench;
   logic clk_sys;
   logic rstn;
   logic tokenValid;
   usas_pkg::usas_token_t tokenKind;
   logic [6:0] tokenAddr;
   logic [9:0] evt;
   logic tokenAccept;
   logic [6:0] deviceAddr;
   logic remoteWakeEn;
   logic [7:0] outStall;
   logic [7:0] inStall;
   logic nakIrq;
   logic cmdValid;
   usas_pkg::usas_cmd_t cmdOp;
   logic [1:0] cmdSel;
   logic [7:0] cmdData;
   logic cmdReady;
   logic [7:0] readData;
   logic readValid;
   logic [7:0] d;
   logic a;
   logic irq;
   logic [7:0] flagExp [0:5];
   int errCount = 0;
   int nTests = 0;
   int k;
   usas_reg_if regIf ();
   // event bits: crc pid stuff noresp fifo out nak busreset indone stagedone
   usas_device u_usas_device (.clk_sys(clk_sys), .rstn(rstn),
      .regPort(regIf), .tokenValid(tokenValid), .tokenKind(tokenKind),
      .tokenAddr(tokenAddr), .busReset(evt[7]), .outDataRx(evt[5]),
      .inReadDone(evt[8]), .crcErr(evt[0]), .pidErr(evt[1]),
      .stuffErr(evt[2]), .noResponse(evt[3]), .fifoErr(evt[4]),
      .nakSent(evt[6]), .tokenAccept(tokenAccept), .deviceAddr(deviceAddr),
      .remoteWakeEn(remoteWakeEn), .outStall(outStall), .inStall(inStall),
      .nakIrq(nakIrq));
   usas_host u_usas_host (.clk_sys(clk_sys), .rstn(rstn), .regPort(regIf),
      .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdSel(cmdSel),
      .cmdData(cmdData), .cmdReady(cmdReady), .setupStageDone(evt[9]),
      .readData(readData), .readValid(readValid));
   usas_reg_asserts u_usas_reg_asserts (.clk_sys(clk_sys), .rstn(rstn),
      .regSel(regIf.regSel), .wrEn(regIf.wrEn), .rdEn(regIf.rdEn),
      .wrData(regIf.wrData), .rdData(regIf.rdData),
      .rdValid(regIf.rdValid), .setupSeen(regIf.setupSeen));
   initial begin
      clk_sys = 1'b0;
      forever #25 clk_sys = ~clk_sys;
   end
   task automatic conclude;
      $display("comparisons %0d mismatches %0d", nTests, errCount);
      if (errCount == 0 && nTests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : conclude
   task automatic overrun;
      errCount++;
      $display("[ERR] %0t wait limit used up", $time);
      conclude();
   endtask : overrun
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      nTests++;
      if (got !== exp) begin
         errCount++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cmd(input usas_pkg::usas_cmd_t op, input logic [1:0] sel,
                      input logic [7:0] data);
      int i;
      @(negedge clk_sys);
      cmdValid = 1'b1;
      cmdOp = op;
      cmdSel = sel;
      cmdData = data;
      for (i = 0; cmdReady !== 1'b1; i++) begin
         if (i > 80) overrun();
         @(negedge clk_sys);
      end
      @(negedge clk_sys);
      cmdValid = 1'b0;
   endtask : cmd
   task automatic rd(input logic [1:0] sel, output logic [7:0] data);
      int i;
      cmd(usas_pkg::CMD_READ, sel, 8'h00);
      for (i = 0; readValid !== 1'b1; i++) begin
         if (i > 8) overrun();
         @(negedge clk_sys);
      end
      data = readData;
   endtask : rd
   task automatic pulse(input logic [9:0] m, output logic irqSeen);
      @(negedge clk_sys);
      evt = m;
      @(negedge clk_sys);
      irqSeen = nakIrq;
      evt = 10'h000;
   endtask : pulse
   task automatic token(input usas_pkg::usas_token_t kind,
                        input logic [6:0] addr, output logic acc);
      @(negedge clk_sys);
      tokenValid = 1'b1;
      tokenKind = kind;
      tokenAddr = addr;
      #1 acc = tokenAccept;
      @(negedge clk_sys);
      tokenValid = 1'b0;
   endtask : token
   initial begin
      rstn = 1'b0;
      tokenValid = 1'b0;
      tokenKind = usas_pkg::TOK_OUT;
      tokenAddr = 7'h00;
      evt = 10'h000;
      cmdValid = 1'b0;
      cmdOp = usas_pkg::CMD_READ;
      cmdSel = 2'h0;
      cmdData = 8'h00;
      flagExp = '{8'h40, 8'h40, 8'h40, 8'h10, 8'h02, 8'h04};
      repeat (10) @(negedge clk_sys);
      rstn = 1'b1;
      for (k = 0; k < 4; k++) begin
         rd(k[1:0], d);
         chk(d, 8'h00);
      end
      chk({1'b0, deviceAddr}, 8'h00);
      $display("test reset values done");
      cmd(usas_pkg::CMD_WRITE, usas_pkg::REG_ADDR, 8'h0B);
      rd(usas_pkg::REG_ADDR, d);
      chk(d, 8'h0B);
      chk({1'b0, deviceAddr}, 8'h05);
      chk({7'h00, remoteWakeEn}, 8'h01);
      token(usas_pkg::TOK_OUT, 7'h03, a);
      chk({7'h00, a}, 8'h00);
      token(usas_pkg::TOK_OUT, 7'h05, a);
      chk({7'h00, a}, 8'h01);
      $display("test address done");
      cmd(usas_pkg::CMD_STALL, usas_pkg::REG_OUT_STALL, 8'h03);
      cmd(usas_pkg::CMD_STALL, usas_pkg::REG_IN_STALL, 8'h07);
      rd(usas_pkg::REG_OUT_STALL, d);
      chk(d, 8'h08);
      chk(inStall, 8'h80);
      token(usas_pkg::TOK_SETUP, 7'h02, a);
      chk(outStall, 8'h08);
      token(usas_pkg::TOK_SETUP, 7'h05, a);
      chk(outStall | inStall, 8'h00);
      cmd(usas_pkg::CMD_WRITE, usas_pkg::REG_IN_STALL, 8'hFF);
      rd(usas_pkg::REG_IN_STALL, d);
      chk(d, 8'hFF);
      pulse(10'h080, irq);
      chk(inStall, 8'h00);
      $display("test stall done");
      cmd(usas_pkg::CMD_WRITE, usas_pkg::REG_STATUS, 8'hFF);
      rd(usas_pkg::REG_STATUS, d);
      chk(d, 8'h81);
      cmd(usas_pkg::CMD_WRITE, usas_pkg::REG_STATUS, 8'h00);
      for (k = 0; k < 6; k++) begin
         pulse(10'h001 << k, irq);
         rd(usas_pkg::REG_STATUS, d);
         chk(d, flagExp[k]);
         rd(usas_pkg::REG_STATUS, d);
         chk(d, flagExp[k]);
         cmd(usas_pkg::CMD_WRITE, usas_pkg::REG_STATUS, 8'h00);
         rd(usas_pkg::REG_STATUS, d);
         chk(d, 8'h00);
      end
      pulse(10'h020, irq);
      token(usas_pkg::TOK_SETUP, 7'h05, a);
      rd(usas_pkg::REG_STATUS, d);
      chk(d, 8'h00);
      token(usas_pkg::TOK_IN, 7'h05, a);
      cmd(usas_pkg::CMD_WRITE, usas_pkg::REG_STATUS, 8'h00);
      rd(usas_pkg::REG_STATUS, d);
      chk(d, 8'h08);
      token(usas_pkg::TOK_OUT, 7'h05, a);
      rd(usas_pkg::REG_STATUS, d);
      chk(d, 8'h00);
      $display("test status flags done");
      pulse(10'h040, irq);
      chk({7'h00, irq}, 8'h01);
      cmd(usas_pkg::CMD_WRITE, usas_pkg::REG_STATUS, 8'h80);
      pulse(10'h040, irq);
      chk({7'h00, irq}, 8'h00);
      cmd(usas_pkg::CMD_WRITE, usas_pkg::REG_STATUS, 8'h81);
      $display("test nak mask done");
      cmd(usas_pkg::CMD_SET_ADDR, usas_pkg::REG_ADDR, 8'h0E);
      k = 0;
      repeat (6) begin
         @(negedge clk_sys);
         if (regIf.wrEn === 1'b1) k++;
      end
      chk(k[7:0], 8'h00);
      pulse(10'h200, irq);
      repeat (4) @(negedge clk_sys);
      chk({1'b0, deviceAddr}, 8'h05);
      pulse(10'h100, irq);
      chk({1'b0, deviceAddr}, 8'h07);
      token(usas_pkg::TOK_SETUP, 7'h07, a);
      chk({7'h00, a}, 8'h01);
      rd(usas_pkg::REG_STATUS, d);
      chk(d, 8'h80);
      rd(usas_pkg::REG_ADDR, d);
      chk(d, 8'h0E);
      chk({7'h00, remoteWakeEn}, 8'h00);
      $display("test deferred address done");
      conclude();
   end
endmodule : usas_sie_address_stall_status_bench
`default_nettype wire
